//--- common/cantc_defines.svh
// Register map, field positions, reset values and timing of the CAN transceiver control
`ifndef CANTC_DEFINES_SVH
`define CANTC_DEFINES_SVH

`define CANTC_CTRL_OFS      8'h00
`define CANTC_STAT_OFS      8'h04

`define CANTC_CTRL_MODE_LSB 0
`define CANTC_CTRL_SLEW_LSB 2
`define CANTC_CTRL_WAKE_EN  4
`define CANTC_CTRL_SPW      5

`define CANTC_STAT_WAKE     0
`define CANTC_STAT_TXDTO    1
`define CANTC_STAT_BUSF     2
`define CANTC_STAT_FAULT    3
`define CANTC_STAT_CODE_LSB 4
`define CANTC_STAT_MODE_LSB 8
`define CANTC_STAT_DRV      10

`define CANTC_MODE_RST      2'h0
`define CANTC_SLEW_RST      2'h0
`define CANTC_WAKE_EN_RST   1'b0
`define CANTC_SPW_RST       1'b0

`define CANTC_RESP_OKAY     2'h0
`define CANTC_RESP_SLVERR   2'h2

`define CANTC_SY_TXD        8
`define CANTC_SY_BUS        7
`define CANTC_SY_WAKE       6
`define CANTC_CMP_GND       4
`define CANTC_CMP_BAT       2
`define CANTC_CMP_FIVE      0

`define CANTC_CLK_MHZ       100
`define CANTC_TXD_TO_US     300
`define CANTC_WIN_US        120
`define CANTC_CLAMP_US      300
`define CANTC_PULSE_NS      500
`define CANTC_SINGLE_NS     2000
`define CANTC_TXD_TO_CYC    (`CANTC_TXD_TO_US * `CANTC_CLK_MHZ)
`define CANTC_WIN_CYC       (`CANTC_WIN_US * `CANTC_CLK_MHZ)
`define CANTC_CLAMP_CYC     (`CANTC_CLAMP_US * `CANTC_CLK_MHZ)
`define CANTC_PULSE_CYC     ((`CANTC_PULSE_NS * `CANTC_CLK_MHZ + 999) / 1000)
`define CANTC_SINGLE_CYC    ((`CANTC_SINGLE_NS * `CANTC_CLK_MHZ + 999) / 1000)
`define CANTC_WAKE_PULSES   2'd3
`define CANTC_CONFIRM       3'd5

`endif

//--- common/cantc_pkg.sv
// Types of the CAN transceiver control block
package cantc_pkg;

  typedef enum logic [1:0] {
    mode_sleep,
    mode_rx_only,
    mode_txrx
  } cantc_mode_type;

  typedef enum logic [2:0] {
    flt_none,
    flt_low_gnd,
    flt_high_gnd,
    flt_low_bat,
    flt_high_bat,
    flt_low_5v,
    flt_high_5v
  } cantc_fault_type;

  typedef struct packed {
    logic [5:0]      rec_smp;
    logic [5:0]      dom_smp;
    logic            prev_dom;
    cantc_fault_type cand;
    logic [2:0]      cnt;
    cantc_fault_type code;
    logic            code_new;
  } cantc_dec_state_type;

  typedef struct packed {
    logic [8:0]      sync1;
    logic [8:0]      sync2;
    cantc_mode_type  mode;
    logic [1:0]      slew;
    logic            wake_en;
    logic            spw;
    logic            armed;
    logic            to_lat;
    logic [15:0]     txd_cnt;
    logic [15:0]     clamp_cnt;
    logic [15:0]     dom_cnt;
    logic [15:0]     win_cnt;
    logic [1:0]      pcnt;
    logic            win_run;
    logic            prev_bus;
    logic            wake_flag;
    logic            txd_flag;
    logic            bus_fail;
    logic            fault_flag;
    logic            alert;
    logic            rxd;
    logic            drv_en;
    logic            drv_dom;
    logic            rin_gnd;
    logic            bias_oe;
    logic            wake_rx_en;
    logic            reg_on;
    logic            aw_full;
    logic            w_full;
    logic [7:0]      awaddr;
    logic [7:0]      wdata;
    logic            wstrb0;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            awrdy;
    logic            wrdy;
    logic            arrdy;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } cantc_state_type;

endpackage

//--- common/cantc_fault_if.sv
// Carrier between the control core and the bus fault decoder
`timescale 1ns/10ps
`default_nettype none
interface cantc_fault_if
  import cantc_pkg::*;
  ();
  logic [5:0]      cmp;
  logic            drv_on;
  logic            drv_dom;
  cantc_fault_type code;
  logic            code_new;

  modport dec (input cmp, input drv_on, input drv_dom, output code, output code_new);
  modport ctl (output cmp, output drv_on, output drv_dom, input code, input code_new);
endinterface
`default_nettype wire

//--- design/cantc_fault_dec.sv
// Bus short-circuit decoder working on the line comparator outputs
`timescale 1ns/10ps
`default_nettype none
`include "cantc_defines.svh"
module cantc_fault_dec
  import cantc_pkg::*;
(
  input  wire logic   aclk,
  input  wire logic   aresetn,
  cantc_fault_if.dec  fi
);

  cantc_dec_state_type q;
  cantc_dec_state_type n;

  // Pairs are {low line, high line}; first sample is recessive, second dominant
  function automatic cantc_fault_type classify(input logic [5:0] r, input logic [5:0] m);
    logic [1:0] rg;
    logic [1:0] mg;
    logic [1:0] rb;
    logic [1:0] mb;
    logic [1:0] r5;
    logic [1:0] m5;
    rg = r[`CANTC_CMP_GND +: 2];
    mg = m[`CANTC_CMP_GND +: 2];
    rb = r[`CANTC_CMP_BAT +: 2];
    mb = m[`CANTC_CMP_BAT +: 2];
    r5 = r[`CANTC_CMP_FIVE +: 2];
    m5 = m[`CANTC_CMP_FIVE +: 2];
    classify = flt_none;
    if (rg == 2'h0 && mg == 2'h1) begin
      classify = flt_low_gnd;
    end else if (rg == 2'h0 && mg == 2'h0) begin
      classify = flt_high_gnd;
    end else if (rb == 2'h3 && mb == 2'h3) begin
      classify = flt_low_bat;
    end else if (rb == 2'h3 && mb == 2'h1) begin
      classify = flt_high_bat;
    end else if (r5 == 2'h3 && m5 == 2'h3) begin
      classify = flt_low_5v;
    end else if (r5 == 2'h3 && m5 == 2'h1) begin
      classify = flt_high_5v;
    end
  endfunction

  always_comb begin
    cantc_fault_type f;
    f = flt_none;
    n = q;
    n.code_new = 1'b0;
    if (!fi.drv_on) begin
      n.prev_dom = 1'b0;
    end else begin
      if (fi.drv_dom) begin
        n.dom_smp = fi.cmp;
      end else begin
        n.rec_smp = fi.cmp;
      end
      n.prev_dom = fi.drv_dom;
      // One recessive-dominant cycle ends at the dominant to recessive edge
      if (q.prev_dom && !fi.drv_dom) begin
        f = classify(q.rec_smp, q.dom_smp);
        if (f == q.cand) begin
          if (q.cnt != `CANTC_CONFIRM) begin
            n.cnt = q.cnt + 3'd1;
          end
        end else begin
          n.cand = f;
          n.cnt  = 3'd1;
        end
        if (n.cnt == `CANTC_CONFIRM && q.code != n.cand) begin
          n.code     = n.cand;
          n.code_new = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign fi.code     = q.code;
  assign fi.code_new = q.code_new;

endmodule // cantc_fault_dec
`default_nettype wire

//--- design/cantc_top.sv
// CAN transceiver control core with AXI4-Lite register access
//
// Summary of operation
// - Transmit/receive mode: driver and receiver on, bus follows transmit, receive reports.
// - Receive-only mode: driver off, transmit ignored, receiver still reports bus.
// - Driver enables only in transmit/receive mode after transmit input is recessive.
// - Enabled driver: transmit high drives recessive, low drives dominant.
// - Active modes: receive output high for recessive bus, low for dominant bus.
// - Three software slew rates, fastest by default.
// - Transmit dominant timeout at least 300 us; controller keeps under 12 dominant bits.
// - Sleep: drivers off, input resistors to ground, mid bias off, wake receiver optional.
// - Bus wake sets a readable flag, pulses host alert, wakes the device.
// - Leaving sleep returns both bus lines to recessive.
// - Software enables or disables bus wake detection.
// - Pattern wake: three dominant pulses over 500 ns within 120 us.
// - Single pulse wake: one dominant pulse of 2.0 us.
// - Ground comparators decode low and high line shorts to ground.
// - Battery comparators decode low and high line shorts to battery.
// - Five volt comparators decode low and high line shorts to five volts.
// - Active modes turn on bus supply and mid bias output.
// - A fault is reported after five equal recessive-dominant cycles.
// - Bus dominant beyond the clamp time in an active mode sets the bus failure flag.
// - Transmit timeout disables driver, releases bus, sets the timeout flag.
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "cantc_defines.svh"
module cantc_top
  import cantc_pkg::*;
#(
  parameter logic [15:0] TXD_TO_CYC = 16'(`CANTC_TXD_TO_CYC),
  parameter logic [15:0] WIN_CYC    = 16'(`CANTC_WIN_CYC),
  parameter logic [15:0] CLAMP_CYC  = 16'(`CANTC_CLAMP_CYC)
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        txd,
  input  wire logic        bus_diff_dominant,
  input  wire logic        wake_rx_dominant,
  input  wire logic        low_line_ground_compare,
  input  wire logic        high_line_ground_compare,
  input  wire logic        low_line_battery_compare,
  input  wire logic        high_line_battery_compare,
  input  wire logic        low_line_five_volt_compare,
  input  wire logic        high_line_five_volt_compare,
  output logic             rxd,
  output logic             driver_enable,
  output logic             driver_dominant,
  output logic             input_res_to_ground,
  output logic             mid_bias_oe,
  output logic             bus_supply_on,
  output logic             wake_rx_enable,
  output logic [1:0]       slew_sel,
  output logic             host_alert_pulse
);

  cantc_state_type s;
  cantc_state_type d;
  logic            txd_s;
  logic            bus_s;
  logic            wk_s;

  cantc_fault_if fi ();

  assign txd_s      = s.sync2[`CANTC_SY_TXD];
  assign bus_s      = s.sync2[`CANTC_SY_BUS];
  assign wk_s       = s.sync2[`CANTC_SY_WAKE];
  assign fi.cmp     = s.sync2[5:0];
  assign fi.drv_on  = s.drv_en;
  assign fi.drv_dom = s.drv_dom;

  cantc_fault_dec u_dec (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fi      (fi)
  );

  always_comb begin
    logic [31:0] rd;
    logic        wake;
    rd   = 32'h0;
    wake = 1'b0;
    d    = s;
    d.sync1 = {txd, bus_diff_dominant, wake_rx_dominant,
               low_line_ground_compare, high_line_ground_compare,
               low_line_battery_compare, high_line_battery_compare,
               low_line_five_volt_compare, high_line_five_volt_compare};
    d.sync2 = s.sync1;
    d.alert = 1'b0;

    // Write address and data are taken independently, answered once both are in
    if (s_axi_awvalid && s.awrdy) begin
      d.aw_full = 1'b1;
      d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wrdy) begin
      d.w_full = 1'b1;
      d.wdata  = s_axi_wdata[7:0];
      d.wstrb0 = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      d.bvalid  = 1'b0;
      d.aw_full = 1'b0;
      d.w_full  = 1'b0;
    end else if (s.aw_full && s.w_full && !s.bvalid) begin
      d.bvalid = 1'b1;
      d.bresp  = `CANTC_RESP_OKAY;
      if ({s.awaddr[7:2], 2'h0} == `CANTC_CTRL_OFS) begin
        if (s.wstrb0) begin
          if (s.wdata[`CANTC_CTRL_MODE_LSB +: 2] != 2'h3) begin
            d.mode = cantc_mode_type'(s.wdata[`CANTC_CTRL_MODE_LSB +: 2]);
            // Commanding transmit/receive again re-arms a timed-out driver
            if (d.mode == mode_txrx) begin
              d.to_lat = 1'b0;
            end
          end
          if (s.wdata[`CANTC_CTRL_SLEW_LSB +: 2] != 2'h3) begin
            d.slew = s.wdata[`CANTC_CTRL_SLEW_LSB +: 2];
          end
          d.wake_en = s.wdata[`CANTC_CTRL_WAKE_EN];
          d.spw     = s.wdata[`CANTC_CTRL_SPW];
        end
      end else if ({s.awaddr[7:2], 2'h0} == `CANTC_STAT_OFS) begin
        if (s.wstrb0) begin
          if (s.wdata[`CANTC_STAT_WAKE]) begin
            d.wake_flag = 1'b0;
          end
          if (s.wdata[`CANTC_STAT_TXDTO]) begin
            d.txd_flag = 1'b0;
          end
          if (s.wdata[`CANTC_STAT_BUSF]) begin
            d.bus_fail = 1'b0;
          end
          if (s.wdata[`CANTC_STAT_FAULT]) begin
            d.fault_flag = 1'b0;
          end
        end
      end else begin
        d.bresp = `CANTC_RESP_SLVERR;
      end
    end
    d.awrdy = !d.aw_full && !d.bvalid;
    d.wrdy  = !d.w_full && !d.bvalid;

    // Read channel
    if (s.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end else if (s_axi_arvalid && s.arrdy) begin
      d.rvalid = 1'b1;
      d.rresp  = `CANTC_RESP_OKAY;
      if ({s_axi_araddr[7:2], 2'h0} == `CANTC_CTRL_OFS) begin
        rd[`CANTC_CTRL_MODE_LSB +: 2] = s.mode;
        rd[`CANTC_CTRL_SLEW_LSB +: 2] = s.slew;
        rd[`CANTC_CTRL_WAKE_EN]       = s.wake_en;
        rd[`CANTC_CTRL_SPW]           = s.spw;
      end else if ({s_axi_araddr[7:2], 2'h0} == `CANTC_STAT_OFS) begin
        rd[`CANTC_STAT_WAKE]          = s.wake_flag;
        rd[`CANTC_STAT_TXDTO]         = s.txd_flag;
        rd[`CANTC_STAT_BUSF]          = s.bus_fail;
        rd[`CANTC_STAT_FAULT]         = s.fault_flag;
        rd[`CANTC_STAT_CODE_LSB +: 3] = fi.code;
        rd[`CANTC_STAT_MODE_LSB +: 2] = s.mode;
        rd[`CANTC_STAT_DRV]           = s.drv_en;
      end else begin
        d.rresp = `CANTC_RESP_SLVERR;
      end
      d.rdata = rd;
    end
    d.arrdy = !d.rvalid;

    // Driver arming and transmit dominant timeout
    if (s.mode == mode_txrx) begin
      if (!s.armed && !s.to_lat && txd_s) begin
        d.armed = 1'b1;
      end
      if (s.armed && !txd_s) begin
        d.txd_cnt = s.txd_cnt + 16'd1;
        if (d.txd_cnt >= TXD_TO_CYC) begin
          d.armed    = 1'b0;
          d.to_lat   = 1'b1;
          d.txd_flag = 1'b1;
          d.txd_cnt  = 16'd0;
        end
      end else begin
        d.txd_cnt = 16'd0;
      end
      // Recessive transmit while the bus turns dominant also re-arms
      if (s.to_lat && txd_s && bus_s && !s.prev_bus) begin
        d.to_lat = 1'b0;
      end
    end else begin
      d.armed   = 1'b0;
      d.txd_cnt = 16'd0;
    end
    d.prev_bus = bus_s;

    // Bus stuck dominant
    if (s.mode != mode_sleep && bus_s) begin
      if (s.clamp_cnt != CLAMP_CYC) begin
        d.clamp_cnt = s.clamp_cnt + 16'd1;
      end
      if (d.clamp_cnt == CLAMP_CYC) begin
        d.bus_fail = 1'b1;
      end
    end else begin
      d.clamp_cnt = 16'd0;
    end

    if (fi.code_new && fi.code != flt_none) begin
      d.fault_flag = 1'b1;
    end

    // Bus wake detection, only while asleep with wake enabled
    if (s.mode == mode_sleep && s.wake_en) begin
      if (s.win_run) begin
        d.win_cnt = s.win_cnt + 16'd1;
        if (d.win_cnt >= WIN_CYC) begin
          d.pcnt    = 2'd0;
          d.win_run = 1'b0;
        end
      end
      if (wk_s) begin
        if (s.dom_cnt != 16'hffff) begin
          d.dom_cnt = s.dom_cnt + 16'd1;
        end
        if (s.spw && d.dom_cnt == 16'(`CANTC_SINGLE_CYC)) begin
          wake = 1'b1;
        end
      end else begin
        d.dom_cnt = 16'd0;
        if (!s.spw && s.dom_cnt > 16'(`CANTC_PULSE_CYC)) begin
          if (d.pcnt == `CANTC_WAKE_PULSES - 2'd1) begin
            wake = 1'b1;
          end else begin
            if (d.pcnt == 2'd0) begin
              d.win_run = 1'b1;
              d.win_cnt = 16'd0;
            end
            d.pcnt = d.pcnt + 2'd1;
          end
        end
      end
      if (wake) begin
        d.wake_flag = 1'b1;
        d.alert     = 1'b1;
        d.mode      = mode_rx_only;
        d.dom_cnt   = 16'd0;
        d.pcnt      = 2'd0;
        d.win_run   = 1'b0;
      end
    end else begin
      d.dom_cnt = 16'd0;
      d.pcnt    = 2'd0;
      d.win_run = 1'b0;
      d.win_cnt = 16'd0;
    end

    // Pin drive, registered from the next state
    d.drv_en     = d.mode == mode_txrx && d.armed;
    d.drv_dom    = d.drv_en && !txd_s;
    d.rxd        = (d.mode == mode_sleep) ? 1'b1 : !bus_s;
    d.rin_gnd    = d.mode == mode_sleep;
    d.bias_oe    = d.mode != mode_sleep;
    d.reg_on     = d.mode != mode_sleep;
    d.wake_rx_en = d.mode == mode_sleep && d.wake_en;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s         <= '0;
      s.mode    <= cantc_mode_type'(`CANTC_MODE_RST);
      s.slew    <= `CANTC_SLEW_RST;
      s.wake_en <= `CANTC_WAKE_EN_RST;
      s.spw     <= `CANTC_SPW_RST;
      s.rxd     <= 1'b1;
      s.rin_gnd <= 1'b1;
    end else begin
      s <= d;
    end
  end

  assign s_axi_awready       = s.awrdy;
  assign s_axi_wready        = s.wrdy;
  assign s_axi_bresp         = s.bresp;
  assign s_axi_bvalid        = s.bvalid;
  assign s_axi_arready       = s.arrdy;
  assign s_axi_rdata         = s.rdata;
  assign s_axi_rresp         = s.rresp;
  assign s_axi_rvalid        = s.rvalid;
  assign rxd                 = s.rxd;
  assign driver_enable       = s.drv_en;
  assign driver_dominant     = s.drv_dom;
  assign input_res_to_ground = s.rin_gnd;
  assign mid_bias_oe         = s.bias_oe;
  assign bus_supply_on       = s.reg_on;
  assign wake_rx_enable      = s.wake_rx_en;
  assign slew_sel            = s.slew;
  assign host_alert_pulse    = s.alert;

endmodule // cantc_top
`default_nettype wire

//--- test/cantc_props.sv
// Concurrent checks on the CAN transceiver control pins
`timescale 1ns/10ps
`default_nettype none
module cantc_props
#(
  parameter logic [15:0] TXD_TO_CYC = 16'd30000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic txd,
  input wire logic bus_diff_dominant,
  input wire logic rxd,
  input wire logic driver_enable,
  input wire logic driver_dominant,
  input wire logic input_res_to_ground,
  input wire logic mid_bias_oe,
  input wire logic bus_supply_on,
  input wire logic wake_rx_enable,
  input wire logic host_alert_pulse
);
  logic [15:0] dom_run_q;

  // Length of the current dominant drive run
  always_ff @(posedge aclk) begin
    if (!aresetn || !driver_dominant) begin
      dom_run_q <= 16'h0000;
    end else if (dom_run_q != 16'hffff) begin
      dom_run_q <= dom_run_q + 16'h0001;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_sleep_drv_off: assert property (input_res_to_ground |-> !driver_enable && !mid_bias_oe)
    else $error("driver or mid bias active in sleep");
  a_active_bias: assert property (mid_bias_oe == bus_supply_on && bus_supply_on != input_res_to_ground)
    else $error("supply and mid bias disagree with mode");
  a_dom_from_txd: assert property (driver_dominant |-> driver_enable && !$past(txd, 3))
    else $error("dominant drive without low transmit input");
  a_rxd_follow: assert property (bus_supply_on && $past(bus_supply_on, 3)
    |-> rxd == !$past(bus_diff_dominant, 3))
    else $error("receive output does not follow bus");
  a_sleep_rxd_high: assert property (!bus_supply_on |-> rxd)
    else $error("receive output low in sleep");
  a_wake_rx_sleep: assert property (wake_rx_enable |-> input_res_to_ground)
    else $error("wake receiver on outside sleep");
  a_txd_timeout: assert property (dom_run_q <= TXD_TO_CYC + 16'h0002)
    else $error("dominant drive outlasts timeout");
  a_alert_wakes: assert property (host_alert_pulse |=> !host_alert_pulse ##[0:3] bus_supply_on)
    else $error("alert not single or no self wake");
  a_alert_enabled: assert property (host_alert_pulse |-> $past(wake_rx_enable))
    else $error("alert while wake detection off");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");

  c_alert: cover property (host_alert_pulse);
  c_dom_rx: cover property (driver_dominant && !rxd);
  c_timeout: cover property (dom_run_q == TXD_TO_CYC);
endmodule // cantc_props

bind cantc_top cantc_props #(.TXD_TO_CYC(TXD_TO_CYC)) u_cantc_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .txd(txd),
  .bus_diff_dominant(bus_diff_dominant), .rxd(rxd), .driver_enable(driver_enable),
  .driver_dominant(driver_dominant), .input_res_to_ground(input_res_to_ground),
  .mid_bias_oe(mid_bias_oe), .bus_supply_on(bus_supply_on),
  .wake_rx_enable(wake_rx_enable), .host_alert_pulse(host_alert_pulse)
);
`default_nettype wire

//--- test/cantc_can_peer.sv
// Protocol controller and bus line model facing the transceiver control
`timescale 1ns/10ps
`default_nettype none
module cantc_can_peer (
  input  wire logic       aclk,
  input  wire logic       tx_low,
  input  wire logic       ext_dom,
  input  wire logic [2:0] fault,
  input  wire logic       driver_dominant,
  output logic            txd,
  output logic            bus_dom,
  output logic            wake_dom,
  output logic [1:0]      gnd_cmp,
  output logic [1:0]      bat_cmp,
  output logic [1:0]      five_cmp
);
  logic dd;

  // Dominant runs stay as short as the bench commands them
  always @(posedge aclk) txd <= !tx_low;
  assign dd = driver_dominant;
  assign bus_dom = dd | ext_dom;
  assign wake_dom = bus_dom;
  // Comparator pairs, low line first
  assign gnd_cmp = (fault == 3'h1) ? {1'b0, dd} :
                   (fault == 3'h2) ? 2'h0 : {!dd, 1'b1};
  assign bat_cmp = (fault == 3'h3) ? 2'h3 :
                   (fault == 3'h4) ? {!dd, 1'b1} : 2'h0;
  assign five_cmp = (fault == 3'h5) ? 2'h3 :
                    (fault == 3'h6) ? {!dd, 1'b1} : 2'h0;
endmodule // cantc_can_peer
`default_nettype wire

//--- test/cantc_top_tb.sv
// Self-checking bench for the CAN transceiver control block
`timescale 1ns/10ps
`default_nettype none
module cantc_top_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, slew, gc, bc, fc;
  logic [31:0] rdata;
  logic        txd, bdom, wdom, rxd, drv_en, drv_dom, rin_gnd, bias_oe, sup_on, wk_en, alert;
  logic        txl = 1'b0, ext = 1'b0;
  logic [2:0]  flt = 3'h0;
  logic [31:0] rng = 32'd54;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          error_cnt = 0, n_checks = 0, alerts = 0;

  cantc_top #(.TXD_TO_CYC(16'd200), .WIN_CYC(16'd300), .CLAMP_CYC(16'd400)) u_cantc_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .txd(txd), .bus_diff_dominant(bdom), .wake_rx_dominant(wdom),
    .low_line_ground_compare(gc[1]), .high_line_ground_compare(gc[0]),
    .low_line_battery_compare(bc[1]), .high_line_battery_compare(bc[0]),
    .low_line_five_volt_compare(fc[1]), .high_line_five_volt_compare(fc[0]),
    .rxd(rxd), .driver_enable(drv_en), .driver_dominant(drv_dom),
    .input_res_to_ground(rin_gnd), .mid_bias_oe(bias_oe), .bus_supply_on(sup_on),
    .wake_rx_enable(wk_en), .slew_sel(slew), .host_alert_pulse(alert));

  cantc_can_peer u_cantc_can_peer (.aclk(aclk), .tx_low(txl), .ext_dom(ext), .fault(flt),
    .driver_dominant(drv_dom), .txd(txd), .bus_dom(bdom), .wake_dom(wdom),
    .gnd_cmp(gc), .bat_cmp(bc), .five_cmp(fc));

  always #5 aclk = ~aclk;

  function automatic int rnd(input int m);
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return int'(rng % 32'(m));
  endfunction

  task automatic close_out();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic pin(input logic got, input logic exp);
    cmp({33'h0, got}, {33'h0, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // One bus transfer; the monitor below checks the answer against the note
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d,
                      input logic [33:0] e);
    bit dn = 1'b0;
    if (w) begin
      bq.push_back(e[1:0]);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      rq.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    for (int n = 0; !dn; n++) begin
      if (n == 60) begin
        error_cnt++;
        close_out();
      end
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (bready && bvalid === 1'b1) begin
        bready <= 1'b0;
        dn = 1'b1;
      end
      if (rready && rvalid === 1'b1) begin
        rready <= 1'b0;
        dn = 1'b1;
      end
    end
    @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 34'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] v);
    xfer(1'b0, a, 32'h0, {2'h0, v});
  endtask

  task automatic pls(input bit bus, input int on, input int off);
    if (bus) ext <= 1'b1;
    else txl <= 1'b1;
    cyc(on);
    ext <= 1'b0;
    txl <= 1'b0;
    cyc(off);
  endtask

  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready === 1'b1) cmp({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (rvalid === 1'b1 && rready === 1'b1) cmp({rresp, rdata}, rq.pop_front());
    if (alert === 1'b1) alerts++;
  end

  initial begin
    logic [2:0] f;
    cyc(5);
    aresetn <= 1'b1;
    cyc(3);
    cmp(34'(slew), 34'h0);
    pin(rin_gnd, 1'b1);
    pin(rxd, 1'b1);
    rd(8'h00, 32'h0);
    xfer(1'b0, 8'h08, 32'h0, {2'h2, 32'h0});
    xfer(1'b1, 8'h0c, 32'h1, 34'h2);
    for (int s = 0; s < 3; s++) begin
      wr(8'h00, 32'h2 | 32'(s << 2));
      cyc(3);
      cmp(34'(slew), 34'(s));
    end
    wr(8'h00, 32'he);
    rd(8'h00, 32'ha);
    cyc(4);
    pin(drv_en, 1'b1);
    pin(bias_oe, 1'b1);
    pin(sup_on, 1'b1);
    txl <= 1'b1;
    cyc(8);
    pin(drv_dom, 1'b1);
    pin(rxd, 1'b0);
    txl <= 1'b0;
    cyc(8);
    pin(rxd, 1'b1);
    for (int i = 0; i < 7; i++) begin
      f = (i == 6) ? 3'h0 : 3'(i + 1);
      flt <= f;
      cyc(6);
      repeat (8) pls(1'b0, 8 + rnd(8), 8 + rnd(8));
      cyc(10);
      rd(8'h04, 32'h600 | {25'h0, f, 4'h0} | ((f != 3'h0) ? 32'h8 : 32'h0));
      wr(8'h04, 32'hf);
    end
    wr(8'h00, 32'h1);
    txl <= 1'b1;
    cyc(10);
    pin(drv_en, 1'b0);
    pin(rxd, 1'b1);
    pin(sup_on, 1'b1);
    txl <= 1'b0;
    ext <= 1'b1;
    cyc(430);
    pin(rxd, 1'b0);
    ext <= 1'b0;
    cyc(5);
    rd(8'h04, 32'h104);
    wr(8'h04, 32'hf);
    wr(8'h00, 32'h2);
    cyc(6);
    txl <= 1'b1;
    cyc(150);
    pin(drv_dom, 1'b1);
    cyc(100);
    pin(drv_en, 1'b0);
    pin(rxd, 1'b1);
    txl <= 1'b0;
    cyc(10);
    pin(drv_en, 1'b0);
    rd(8'h04, 32'h202);
    wr(8'h00, 32'h2);
    cyc(6);
    pin(drv_en, 1'b1);
    wr(8'h04, 32'hf);
    wr(8'h00, 32'h10);
    cyc(4);
    pin(wk_en, 1'b1);
    pin(bias_oe, 1'b0);
    repeat (2) pls(1'b1, 60, 15 + rnd(10));
    cyc(350);
    repeat (2) pls(1'b1, 60, 15 + rnd(10));
    pls(1'b1, 40, 15 + rnd(10));
    cmp(34'(alerts), 34'h0);
    pls(1'b1, 60, 10);
    cmp(34'(alerts), 34'h1);
    pin(sup_on, 1'b1);
    rd(8'h04, 32'h101);
    wr(8'h04, 32'hf);
    wr(8'h00, 32'h0);
    cyc(4);
    pin(wk_en, 1'b0);
    repeat (3) pls(1'b1, 60, 20);
    cmp(34'(alerts), 34'h1);
    wr(8'h00, 32'h30);
    pls(1'b1, 190, 20);
    cmp(34'(alerts), 34'h1);
    pls(1'b1, 210, 20);
    cmp(34'(alerts), 34'h2);
    rd(8'h04, 32'h101);
    wr(8'h00, 32'h2);
    cyc(8);
    pin(drv_dom, 1'b0);
    pin(rin_gnd, 1'b0);
    pin(rxd, 1'b1);
    close_out();
  end
endmodule // cantc_top_tb
`default_nettype wire
